// >>> sbl_pkg.sv
// Constants, codes and state types shared by the serial boot loader command handler.
`default_nettype none
package sbl_pkg;
	// ************************************************************
	// Protocol byte codes
	// ************************************************************
	localparam logic [7:0] MATCH1_A = 8'h86;
	localparam logic [7:0] MATCH1_B = 8'h30;
	localparam logic [7:0] MATCH2_A = 8'h79;
	localparam logic [7:0] MATCH2_B = 8'hcf;
	localparam logic [7:0] CMD_RAM_LOAD = 8'h60;
	localparam logic [7:0] CMD_FLASH_SUM = 8'h90;
	localparam logic [7:0] ERR_FRAME = 8'ha1;
	localparam logic [7:0] ERR_CMD = 8'ha3;
	localparam logic [7:0] ERR_OVERRUN = 8'h63;
	localparam logic [7:0] SUM_ALL_FF = 8'haa;
	localparam logic [7:0] SUM_NOT_FF = 8'h55;
	localparam logic [7:0] PAD_BYTE = 8'h00;

	// ************************************************************
	// Counts and field positions
	// ************************************************************
	localparam int SBL_CW = 16;
	localparam logic [1:0] ERR_REPEAT = 2'd3;
	localparam logic [3:0] UART_FRAME_BITS = 4'd10;
	localparam logic [3:0] UART_STOP_IDX = 4'd9;
	localparam logic [2:0] PW_ADDR_LAST = 3'd5;
	localparam logic [2:0] PW_CNT_BYTES = 3'd3;
	localparam logic [SBL_CW-1:0] AB_MIN_RUN = 16'd4;

	// ************************************************************
	// Types
	// ************************************************************
	typedef enum logic [12:0] {
		ST_AB_WAIT = 13'h0001, ST_AB_LOW = 13'h0002, ST_AB_HIGH = 13'h0004, ST_AB_SKIP = 13'h0008,
		ST_MATCH2 = 13'h0010, ST_CMD = 13'h0020, ST_PWADDR = 13'h0040, ST_PWSTR = 13'h0080,
		ST_RECS = 13'h0100, ST_TXQ = 13'h0200, ST_JUMP = 13'h0400, ST_DONE = 13'h0800,
		ST_LOCK = 13'h1000
	} sbl_state_t;

	typedef enum logic [1:0] {PH_NONE = 2'd0, PH_PW_STR = 2'd1, PH_RECORD = 2'd2} sbl_phase_t;

	typedef struct packed {
		logic security_on;
		logic pw_blank;
		logic pw_ok;
		logic pw_err;
		logic rec_ok;
		logic rec_err;
		logic [15:0] load_sum;
		logic [15:0] flash_sum;
		logic flash_all_ff;
	} sbl_sys_in_t;

	typedef struct packed {
		logic byte_valid;
		logic [7:0] byte_data;
		sbl_phase_t phase;
		logic [23:0] pw_cnt_addr;
		logic [23:0] pw_cmp_addr;
		logic addr_valid;
		logic jump;
		logic locked;
	} sbl_sys_out_t;

	typedef struct packed {
		sbl_state_t st;
		sbl_state_t ret;
		logic [SBL_CW-1:0] ab_cnt;
		logic [SBL_CW-1:0] ab_run;
		logic ab_ok;
		logic [7:0] ab_byte;
		logic [SBL_CW-1:0] bit_len;
		logic rx_busy;
		logic [SBL_CW-1:0] rx_cnt;
		logic [3:0] rx_idx;
		logic [7:0] rx_sh;
		logic got;
		logic ferr;
		logic [SBL_CW-1:0] tx_cnt;
		logic [3:0] tx_idx;
		logic [9:0] tx_sh;
		logic txd;
		logic [23:0] q;
		logic [1:0] q_left;
		logic [2:0] idx;
		sbl_sys_out_t out;
	} sbl_regs_t;
endpackage : sbl_pkg
`default_nettype wire

// >>> sbl_loader.sv
// Serial boot command handler: auto baud, matching bytes, RAM load and flash checksum report.
`timescale 1ns/1ps
`default_nettype none

// Function
// - First matching byte 0x86/0x30 echoed, else silent
// - Bit rate measured from first matching byte
// - Second matching byte 0x79/0xCF echoed, else silent
// - Command 0x60 starts RAM load, echoed
// - Bad command sends error byte thrice, then locks
// - Blank password area skips the password string
// - Bad password address locks until reset
// - Security or password error: silent until reset, except a command framing error sends 0xA1 thrice
// - Framing error during password phase locks
// - Load checksum sent high then low byte
// - After checksum, jump into loaded RAM program
// - Command 0x90 requests flash checksum report
// - Status byte 0xAA if all 0xFF, else 0x55
// - Flash checksum follows, high then low byte
// - After report, await next command byte
module sbl_loader (
	input wire logic clk,
	input wire logic reset,
	input wire logic rxd,
	output logic txd,
	input wire sbl_pkg::sbl_sys_in_t sys_i,
	output sbl_pkg::sbl_sys_out_t sys_o
);
	import sbl_pkg::*;

	sbl_regs_t s;
	sbl_regs_t n;

	// Queues up to three reply bytes; the low byte leaves first.
	function automatic sbl_regs_t push(sbl_regs_t r, logic [23:0] b, logic [1:0] k, sbl_state_t ret);
		sbl_regs_t t;
		t = r;
		t.q = b;
		t.q_left = k;
		t.ret = ret;
		t.st = ST_TXQ;
		return t;
	endfunction : push

	// ************************************************************
	// Next-state logic
	// ************************************************************
	// The receiver only listens once the rate is known, and stops for good on lockout.
	always_comb begin
		logic tx_idle;
		logic rx_on;
		logic [SBL_CW+2:0] hx;
		logic [SBL_CW+2:0] l2;
		logic is86;
		logic is30;
		n = s;
		tx_idle = (s.tx_cnt == '0) && (s.tx_idx == '0);
		rx_on = (s.st == ST_MATCH2) || (s.st == ST_CMD) || (s.st == ST_PWADDR) || (s.st == ST_PWSTR)
			|| (s.st == ST_RECS) || (s.st == ST_TXQ);
		hx = {3'b000, s.ab_cnt};
		l2 = '0;
		is86 = 1'b0;
		is30 = 1'b0;
		n.got = 1'b0;
		n.out.byte_valid = 1'b0;
		n.out.addr_valid = 1'b0;
		n.out.jump = 1'b0;

		// Transmitter: ten bit times per frame at the measured rate.
		if (s.tx_cnt != '0) begin
			n.tx_cnt = s.tx_cnt - 1'b1;
		end else if (s.tx_idx != '0) begin
			n.txd = s.tx_sh[0];
			n.tx_sh = {1'b1, s.tx_sh[9:1]};
			n.tx_idx = s.tx_idx - 1'b1;
			n.tx_cnt = s.bit_len - 1'b1;
		end

		// Receiver: sample mid-bit; a high start sample is a glitch and is dropped.
		if (!rx_on) begin
			n.rx_busy = 1'b0;
		end else if (!s.rx_busy) begin
			if (!rxd) begin
				n.rx_busy = 1'b1;
				n.rx_cnt = {1'b0, s.bit_len[SBL_CW-1:1]};
				n.rx_idx = '0;
			end
		end else if (s.rx_cnt != '0) begin
			n.rx_cnt = s.rx_cnt - 1'b1;
		end else begin
			n.rx_cnt = s.bit_len - 1'b1;
			n.rx_idx = s.rx_idx + 1'b1;
			if (s.rx_idx == '0) begin
				if (rxd) begin
					n.rx_busy = 1'b0;
				end
			end else if (s.rx_idx == UART_STOP_IDX) begin
				n.rx_busy = 1'b0;
				n.got = 1'b1;
				n.ferr = !rxd;
			end else begin
				n.rx_sh = {rxd, s.rx_sh[7:1]};
			end
		end

		// Command sequencer.
		case (s.st)
			ST_AB_WAIT: begin
				if (!rxd) begin
					n.st = ST_AB_LOW;
					n.ab_cnt = 16'd1;
				end
			end
			ST_AB_LOW: begin
				if (rxd) begin
					n.ab_run = s.ab_cnt;
					n.ab_cnt = 16'd1;
					n.st = ST_AB_HIGH;
				end else if (&s.ab_cnt) begin
					n.st = ST_AB_WAIT;
				end else begin
					n.ab_cnt = s.ab_cnt + 1'b1;
				end
			end
			ST_AB_HIGH: begin
				// Both codes have a two-bit high run after the first low run; 0x86 has a
				// two-bit low run, 0x30 a five-bit one. Accept 0x86 within a quarter, 0x30 within a fifth.
				if (!rxd) begin
					l2 = {2'b00, s.ab_run, 1'b0};
					is86 = (l2 >= hx + (hx >> 1)) && (l2 <= (hx << 1) + (hx >> 1));
					is30 = (l2 >= (hx << 2)) && (l2 <= (hx << 2) + (hx << 1));
					n.ab_ok = (is86 || is30) && (s.ab_cnt >= AB_MIN_RUN);
					n.ab_byte = is86 ? MATCH1_A : MATCH1_B;
					if ((is86 || is30) && (s.ab_cnt >= AB_MIN_RUN)) begin
						n.bit_len = {1'b0, s.ab_cnt[SBL_CW-1:1]};
					end
					n.ab_run = s.ab_cnt;
					n.ab_cnt = '0;
					n.st = ST_AB_SKIP;
				end else if (&s.ab_cnt) begin
					n.st = ST_AB_WAIT;
				end else begin
					n.ab_cnt = s.ab_cnt + 1'b1;
				end
			end
			ST_AB_SKIP: begin
				// Wait out the frame: no high run inside it exceeds two bit times.
				if (!rxd) begin
					n.ab_cnt = '0;
				end else if ({1'b0, s.ab_cnt} >= {1'b0, s.ab_run} + {2'b00, s.ab_run[SBL_CW-1:1]}) begin
					if (s.ab_ok) begin
						n = push(n, {16'h0000, s.ab_byte}, 2'd1, ST_MATCH2);
					end else begin
						n.st = ST_AB_WAIT;
					end
				end else begin
					n.ab_cnt = s.ab_cnt + 1'b1;
				end
			end
			ST_MATCH2: begin
				if (s.got && !s.ferr && (s.rx_sh == MATCH2_A || s.rx_sh == MATCH2_B)) begin
					n = push(n, {16'h0000, s.rx_sh}, 2'd1, ST_CMD);
				end
			end
			ST_CMD: begin
				if (s.got) begin
					if (s.ferr) begin
						n = push(n, {3{ERR_FRAME}}, ERR_REPEAT, ST_LOCK);
					end else if (sys_i.security_on) begin
						n.st = ST_LOCK;
					end else if (s.rx_sh == CMD_RAM_LOAD) begin
						n = push(n, {16'h0000, CMD_RAM_LOAD}, 2'd1, ST_PWADDR);
						n.idx = '0;
					end else if (s.rx_sh == CMD_FLASH_SUM) begin
						// Status, then checksum high, then low; the handler then waits again.
						n = push(n, {sys_i.flash_sum[7:0], sys_i.flash_sum[15:8],
							sys_i.flash_all_ff ? SUM_ALL_FF : SUM_NOT_FF}, 2'd3, ST_CMD);
					end else begin
						n = push(n, {3{ERR_CMD}}, ERR_REPEAT, ST_LOCK);
					end
				end
			end
			ST_PWADDR: begin
				if (s.got) begin
					if (s.ferr) begin
						n.st = ST_LOCK;
					end else begin
						if (s.idx < PW_CNT_BYTES) begin
							n.out.pw_cnt_addr = {s.out.pw_cnt_addr[15:0], s.rx_sh};
						end else begin
							n.out.pw_cmp_addr = {s.out.pw_cmp_addr[15:0], s.rx_sh};
						end
						n.idx = s.idx + 1'b1;
						if (s.idx == PW_ADDR_LAST) begin
							n.out.addr_valid = 1'b1;
							n.st = sys_i.pw_blank ? ST_RECS : ST_PWSTR;
						end
					end
				end
			end
			ST_PWSTR: begin
				if (sys_i.pw_err || (s.got && s.ferr)) begin
					n.st = ST_LOCK;
				end else if (sys_i.pw_ok) begin
					n.st = ST_RECS;
				end else if (s.got) begin
					n.out.byte_valid = 1'b1;
					n.out.byte_data = s.rx_sh;
				end
			end
			ST_RECS: begin
				if (sys_i.pw_err || sys_i.rec_err || (s.got && s.ferr)) begin
					n.st = ST_LOCK;
				end else if (sys_i.rec_ok) begin
					n = push(n, {PAD_BYTE, sys_i.load_sum[7:0], sys_i.load_sum[15:8]}, 2'd2, ST_JUMP);
				end else if (s.got) begin
					n.out.byte_valid = 1'b1;
					n.out.byte_data = s.rx_sh;
				end
			end
			ST_TXQ: begin
				// A byte landing while a reply other than an error or the load checksum is leaving means the controller overran us.
				if (s.got && s.ret != ST_LOCK && s.ret != ST_JUMP) begin
					n = push(n, {3{ERR_OVERRUN}}, ERR_REPEAT, ST_LOCK);
				end else if (tx_idle && s.q_left != '0) begin
					n.tx_sh = {1'b1, s.q[7:0], 1'b0};
					n.tx_idx = UART_FRAME_BITS;
					n.tx_cnt = '0;
					n.q = {8'h00, s.q[23:8]};
					n.q_left = s.q_left - 1'b1;
				end else if (tx_idle) begin
					n.st = s.ret;
				end
			end
			ST_JUMP: begin
				n.out.jump = 1'b1;
				n.st = ST_DONE;
			end
			ST_DONE: begin
				n.st = ST_DONE;
			end
			ST_LOCK: begin
				n.st = ST_LOCK;
			end
			default: begin
				n.st = ST_LOCK;
			end
		endcase
		n.out.phase = (n.st == ST_PWSTR) ? PH_PW_STR : (n.st == ST_RECS) ? PH_RECORD : PH_NONE;
		n.out.locked = (n.st == ST_LOCK);
	end

	// ************************************************************
	// State register
	// ************************************************************
	// Only the reset pin leaves the lockout state.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			s <= '0;
			s.st <= ST_AB_WAIT;
			s.ret <= ST_AB_WAIT;
			s.txd <= 1'b1;
		end else begin
			s <= n;
		end
	end

	assign txd = s.txd;
	assign sys_o = s.out;

	// ************************************************************
	// Checks
	// ************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	lock_sticky_a: assert property (s.out.locked |=> s.out.locked) else $error("lockout left without reset");
	lock_silent_a: assert property (s.st == ST_LOCK && s.tx_idx == '0 && s.tx_cnt == '0 |-> s.txd [*8])
		else $error("line driven low while locked");
	ram_echo_a: assert property (s.st == ST_CMD && s.got && !s.ferr && !sys_i.security_on && s.rx_sh == CMD_RAM_LOAD
		|=> s.st == ST_TXQ && s.q[7:0] == CMD_RAM_LOAD && s.q_left == 2'd1 && s.ret == ST_PWADDR)
		else $error("load command not echoed");
	frame_err_a: assert property (s.st == ST_CMD && s.got && s.ferr
		|=> s.q == {3{ERR_FRAME}} && s.q_left == 2'd3 && s.ret == ST_LOCK) else $error("error pattern wrong");
	sum_report_a: assert property (s.st == ST_CMD && s.got && !s.ferr && !sys_i.security_on && s.rx_sh == CMD_FLASH_SUM
		|=> s.q[7:0] == ($past(sys_i.flash_all_ff) ? SUM_ALL_FF : SUM_NOT_FF) && s.q[15:8] == $past(sys_i.flash_sum[15:8])
		&& s.q_left == 2'd3 && s.ret == ST_CMD) else $error("checksum report order wrong");
	match2_bad_a: assert property (s.st == ST_MATCH2 && s.got && s.rx_sh != MATCH2_A && s.rx_sh != MATCH2_B
		|=> s.st == ST_MATCH2) else $error("bad second matching byte answered");
	rate_hold_a: assert property (s.st != ST_AB_HIGH |=> $stable(s.bit_len)) else $error("bit rate changed");
	jump_after_a: assert property (s.st == ST_TXQ && s.ret == ST_JUMP && s.q_left == '0 && s.tx_idx == '0 && s.tx_cnt == '0
		|=> ##1 s.out.jump) else $error("no jump after checksum");
	blank_skip_a: assert property (s.st == ST_PWADDR && s.got && !s.ferr && s.idx == PW_ADDR_LAST && sys_i.pw_blank
		|=> s.st == ST_RECS && s.out.addr_valid) else $error("blank area did not skip string");
	pwstr_ferr_a: assert property (s.st == ST_PWSTR && s.got && s.ferr |=> s.out.locked)
		else $error("framing error in password not locked");
	load_sum_a: assert property (s.st == ST_RECS && sys_i.rec_ok && !sys_i.rec_err && !sys_i.pw_err && !(s.got && s.ferr)
		|=> s.q[7:0] == $past(sys_i.load_sum[15:8]) && s.q_left == 2'd2) else $error("load checksum order wrong");

	sync_done_c: cover property (s.st == ST_MATCH2 ##[1:1000] s.st == ST_CMD);
	jump_c: cover property (s.out.jump);
	report_c: cover property (s.st == ST_TXQ && s.ret == ST_CMD && s.q_left == 2'd3);
	lock_c: cover property ($rose(s.out.locked));
endmodule : sbl_loader
`default_nettype wire

// >>> sbl_ctrl_model.sv
// Behavioural model of the external programming controller on the serial link.
`timescale 1ns/1ps
`default_nettype none
module sbl_ctrl_model #(
	parameter int BL = 16
) (
	input wire logic clk,
	input wire logic line_in,
	output logic line_out
);
	// The line rests high; a frame is start, eight bits LSB first, then stop.
	initial line_out = 1'b1;

	// A cleared stop flag sends a low stop bit, then restores the idle level.
	task automatic send(input logic [7:0] b, input logic stop);
		logic [9:0] f;
		f = {stop, b, 1'b0};
		repeat (4) @(posedge clk);
		for (int i = 0; i < 10; i++) begin
			line_out <= f[i];
			repeat (BL) @(posedge clk);
		end
		// Returning at once keeps the caller in time for the error reply that follows.
		if (!stop) begin
			line_out <= 1'b1;
		end
	endtask : send

	// Returns early in the stop bit so back-to-back replies are not missed.
	task automatic recv(output logic [7:0] b, output logic ok);
		int n;
		n = 0;
		ok = 1'b0;
		b = 8'h00;
		while (line_in !== 1'b0 && n < 40 * BL) begin
			@(posedge clk);
			n++;
		end
		if (n < 40 * BL) begin
			repeat (BL / 2) @(posedge clk);
			for (int i = 0; i < 8; i++) begin
				repeat (BL) @(posedge clk);
				b[i] = line_in;
			end
			repeat (BL) @(posedge clk);
			ok = (line_in === 1'b1);
			repeat (BL / 2 - 2) @(posedge clk);
		end
	endtask : recv
endmodule : sbl_ctrl_model
`default_nettype wire

// >>> tb_sbl_loader.sv
// Self-checking bench for the serial boot command handler.
`timescale 1ns/1ps
`default_nettype none
module tb_sbl_loader;
	import sbl_pkg::*;
	localparam int BL = 16;
	logic clk = 1'b0;
	logic reset = 1'b1;
	wire logic rxd;
	wire logic txd;
	sbl_sys_in_t si = '0;
	sbl_sys_out_t so;
	int bad_count = 0;
	int checks = 0;
	int nbv;
	int nav;
	int njp;
	logic [7:0] lb;
	sbl_phase_t lph;

	// Clock at 100 MHz.
	always #5 clk = ~clk;

	sbl_loader dut (.clk(clk), .reset(reset), .rxd(rxd), .txd(txd), .sys_i(si), .sys_o(so));
	sbl_ctrl_model #(.BL(BL)) m (.clk(clk), .line_in(txd), .line_out(rxd));

	// Pulse counters clear with reset, so each scenario starts clean.
	always @(posedge clk) begin
		if (reset) begin
			nbv <= 0;
			nav <= 0;
			njp <= 0;
		end else begin
			if (so.byte_valid === 1'b1) begin
				nbv <= nbv + 1;
				lb <= so.byte_data;
				lph <= so.phase;
			end
			if (so.addr_valid === 1'b1) nav <= nav + 1;
			if (so.jump === 1'b1) njp <= njp + 1;
		end
	end

	// ****
	// Shared tasks
	// ****
	task automatic check(input logic [23:0] s, input logic [23:0] e);
		checks++;
		if (s !== e) begin
			bad_count++;
			$display("CHECK FAILED %0t seen %h want %h", $time, s, e);
		end
	endtask : check

	task automatic final_report;
		if (bad_count == 0 && checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : final_report

	task automatic rx(input logic [7:0] e);
		logic [7:0] b;
		logic ok;
		m.recv(b, ok);
		check({15'h0, ok, b}, {16'h1, e});
	endtask : rx

	// Counts cycles with the transmit line away from idle.
	task automatic quiet(input int n);
		int lo;
		lo = 0;
		repeat (n) begin
			@(posedge clk);
			if (txd !== 1'b1) lo++;
		end
		check(lo[23:0], 24'h0);
	endtask : quiet

	task automatic rst;
		reset <= 1'b1;
		si <= '0;
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		check({20'h0, txd, so.locked, so.phase}, 24'h8);
	endtask : rst

	task automatic sync(input logic [7:0] a, input logic [7:0] b);
		m.send(a, 1'b1);
		rx(a);
		m.send(b, 1'b1);
		rx(b);
	endtask : sync

	// ****
	// Scenarios
	// ****
	task automatic t_sum;
		rst();
		si.flash_all_ff <= 1'b1;
		si.flash_sum <= 16'h1234;
		sync(8'h86, 8'h79);
		m.send(8'h90, 1'b1);
		rx(8'haa);
		rx(8'h12);
		rx(8'h34);
		si.flash_all_ff <= 1'b0;
		si.flash_sum <= 16'hbeef;
		m.send(8'h90, 1'b1);
		rx(8'h55);
		rx(8'hbe);
		rx(8'hef);
	endtask : t_sum

	task automatic t_load(input logic blank);
		rst();
		si.pw_blank <= blank;
		sync(8'h30, 8'hcf);
		m.send(8'h60, 1'b1);
		rx(8'h60);
		for (int i = 0; i < 6; i++) m.send(8'h12 + 8'(i * 17), 1'b1);
		check(so.pw_cnt_addr, 24'h122334);
		check(so.pw_cmp_addr, 24'h455667);
		check(24'(nav), 24'h1);
		if (!blank) begin
			m.send(8'ha5, 1'b1);
			check({lb, 14'h0, lph}, {8'ha5, 14'h0, PH_PW_STR});
			si.pw_ok <= 1'b1;
			@(posedge clk);
			si.pw_ok <= 1'b0;
			@(posedge clk);
		end
		@(posedge clk);
		check({22'h0, so.phase}, {22'h0, PH_RECORD});
		m.send(8'h3c, 1'b1);
		check({lb, 14'h0, lph}, {8'h3c, 14'h0, PH_RECORD});
		quiet(4 * BL);
		si.load_sum <= 16'hc3e1;
		si.rec_ok <= 1'b1;
		@(posedge clk);
		si.rec_ok <= 1'b0;
		rx(8'hc3);
		rx(8'he1);
		// The receive task returns two cycles before the end of the stop bit; the jump follows the end of that bit.
		repeat (4) @(posedge clk);
		check(24'(njp), 24'h1);
	endtask : t_load

	task automatic t_err(input logic [7:0] code);
		rst();
		sync(8'h86, 8'h79);
		m.send(code == ERR_CMD ? 8'h12 : 8'h60, code != ERR_FRAME);
		for (int i = 0; i < 3; i++) rx(code);
		repeat (4) @(posedge clk);
		check({23'h0, so.locked}, 24'h1);
		m.send(8'h86, 1'b1);
		quiet(12 * BL);
	endtask : t_err

	// A byte lands while the report is going out; the reply bytes before the error may vary.
	task automatic t_ovr;
		logic [7:0] b;
		logic ok;
		int n;
		rst();
		sync(8'h86, 8'h79);
		fork
			begin
				m.send(8'h90, 1'b1);
				m.send(8'h86, 1'b1);
			end
			begin
				n = 0;
				do begin
					m.recv(b, ok);
					n++;
				end while (b !== ERR_OVERRUN && n < 4);
			end
		join
		check({16'h0, b}, {16'h0, ERR_OVERRUN});
		rx(ERR_OVERRUN);
		rx(ERR_OVERRUN);
		repeat (4) @(posedge clk);
		check({23'h0, so.locked}, 24'h1);
	endtask : t_ovr

	task automatic t_sec;
		rst();
		si.security_on <= 1'b1;
		// A first byte with the wrong run ratio must get no echo.
		m.send(8'h0f, 1'b1);
		quiet(12 * BL);
		m.send(8'h86, 1'b1);
		rx(8'h86);
		m.send(8'h11, 1'b1);
		quiet(12 * BL);
		m.send(8'h79, 1'b1);
		rx(8'h79);
		m.send(8'h60, 1'b1);
		quiet(12 * BL);
		check({23'h0, so.locked}, 24'h1);
	endtask : t_sec

	task automatic t_lock(input logic ferr);
		rst();
		sync(8'h86, 8'hcf);
		m.send(8'h60, 1'b1);
		rx(8'h60);
		for (int i = 0; i < 6; i++) m.send(8'h11, !(ferr && i == 2));
		if (!ferr) begin
			m.send(8'h5a, 1'b1);
			si.pw_err <= 1'b1;
			@(posedge clk);
			si.pw_err <= 1'b0;
			@(posedge clk);
		end
		@(posedge clk);
		check({23'h0, so.locked}, 24'h1);
		m.send(8'h86, 1'b1);
		quiet(12 * BL);
		check(24'(nbv), {23'h0, !ferr});
	endtask : t_lock

	// A record error locks the handler silently; a late success is ignored.
	task automatic t_recerr;
		rst();
		si.pw_blank <= 1'b1;
		sync(8'h86, 8'h79);
		m.send(8'h60, 1'b1);
		rx(8'h60);
		for (int i = 0; i < 6; i++) m.send(8'h21, 1'b1);
		m.send(8'h3c, 1'b1);
		si.load_sum <= 16'hc3e1;
		si.rec_err <= 1'b1;
		@(posedge clk);
		si.rec_err <= 1'b0;
		si.rec_ok <= 1'b1;
		@(posedge clk);
		si.rec_ok <= 1'b0;
		quiet(12 * BL);
		check({23'h0, so.locked}, 24'h1);
		check(24'(njp), 24'h0);
	endtask : t_recerr

	// Main sequence.
	initial begin
		rst();
		t_sum();
		t_load(1'b0);
		t_load(1'b1);
		t_err(ERR_CMD);
		t_err(ERR_FRAME);
		t_ovr();
		t_sec();
		t_lock(1'b0);
		t_lock(1'b1);
		t_recerr();
		final_report();
	end

	// Watchdog well beyond the expected run of about 20000 cycles.
	initial begin
		repeat (60000) @(posedge clk);
		bad_count++;
		final_report();
	end
endmodule : tb_sbl_loader
`default_nettype wire
